/* File: shared/hbs_regs.svh */
// Constants of the ballast sequencer
// Contract
// - Start only on threshold, high sense, clear low
// - Lockout holds outputs off, clears counters, keeps polarity
// - Ignition timer restarts only on entry from lockout
// - Strike timer ticks form ignition base clock
// - Divide by 128, strike 21s on 64s off
// - Strike output high enables ignition switch
// - No ignition in 1180s latches fault
// - Low lamp voltage stops strike timer
// - General mode compares sense against limits
// - Bridge oscillates right after lockout exit
// - Ramp top tick toggles both gate pairs
// - Fixed dead-time holds all gates off
// - Strike output low through dead-time
// - Bridge stops only in fault or lockout
// - Fault latches off until clear or lockout
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH
`define HBS_BASE_MS      666
`define HBS_DIV          128
`define HBS_ON_S         21
`define HBS_OFF_S        64
`define HBS_TIMEOUT_S    1180
`define HBS_DEAD_NS      1000
`define HBS_CLK_NS       10
`define HBS_DEAD_CYC     ((`HBS_DEAD_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
// Seconds scaled to base ticks: s*1000/666, on and off rounded, time-out truncated
`define HBS_ON_TK        ((`HBS_ON_S * 1000 + `HBS_BASE_MS / 2) / `HBS_BASE_MS)
`define HBS_OFF_TK       ((`HBS_OFF_S * 1000 + `HBS_BASE_MS / 2) / `HBS_BASE_MS)
`define HBS_TOUT_TK      ((`HBS_TIMEOUT_S * 1000) / `HBS_BASE_MS)
`endif

/* File: shared/hbs_pkg.sv */
// Types of the ballast sequencer
package hbs_pkg;
  typedef enum logic [2:0] {
    HBS_LOCKOUT,
    HBS_IGNITION,
    HBS_GENERAL,
    HBS_BUCK_OFF,
    HBS_FAULT
  } hbs_mode_e;
endpackage : hbs_pkg

/* File: logic/hbs_sequencer.sv */
// Mode sequencer with bridge driver and strike timer
`timescale 1ns/1ps
`include "hbs_regs.svh"
module hbs_sequencer
  import hbs_pkg::*;
#(
  parameter int DEAD_CYC = `HBS_DEAD_CYC,
  parameter int DIV      = `HBS_DIV,
  parameter int ON_TK    = `HBS_ON_TK,
  parameter int OFF_TK   = `HBS_OFF_TK,
  parameter int TOUT_TK  = `HBS_TOUT_TK
)(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Comparator levels
  input  wire logic i_startup_threshold,
  input  wire logic i_above_upper_volt_limit,
  input  wire logic i_below_two_fifths_limit,
  input  wire logic i_fault_clear,
  input  wire logic i_over_voltage_limit_level,
  input  wire logic i_over_current_limit_level,
  input  wire logic i_fault_request,
  // Ramp ticks
  input  wire logic i_strike_timer_tick,
  input  wire logic i_bridge_ramp_tick,
  // Power stage
  output logic      o_high_side_a_gate,
  output logic      o_low_side_a_gate,
  output logic      o_high_side_b_gate,
  output logic      o_low_side_b_gate,
  output logic      o_buck_enable,
  output logic      o_strike_pulse_enable,
  output logic      o_fault_latch,
  output logic [2:0] o_mode
);
  localparam int IN_W = 9;
  logic [1:0]      rst_sync;
  logic            rst_n;
  logic [IN_W-1:0] s1, s2, s3;
  logic            supply_ok, vhigh, vlow, fclr;
  logic            ovl, ocl, freq;
  logic            tick_ign, tick_brg;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else if (i_ce)
    begin
      s1 <= {i_startup_threshold, i_above_upper_volt_limit,
             i_below_two_fifths_limit, i_fault_clear,
             i_over_voltage_limit_level, i_over_current_limit_level,
             i_fault_request, i_strike_timer_tick, i_bridge_ramp_tick};
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign supply_ok = s2[8];
  assign vhigh     = s2[7];
  assign vlow      = s2[6];
  assign fclr      = s2[5];
  assign ovl       = s2[4];
  assign ocl       = s2[3];
  assign freq      = s2[2];
  assign tick_ign  = s2[1] & ~s3[1];
  assign tick_brg  = s2[0] & ~s3[0];

  hbs_mode_e   mode, next_mode;
  logic [7:0]  div_cnt, next_div_cnt;
  logic [10:0] tout_cnt, next_tout_cnt;
  logic        polarity, next_polarity;
  logic [7:0]  dead_cnt, next_dead_cnt;
  logic        running, div_wrap, dead;

  assign running  = (mode != HBS_LOCKOUT) && (mode != HBS_FAULT);
  assign dead     = dead_cnt != 8'h00;
  assign div_wrap = div_cnt == 8'(DIV - 1);

  always_comb
  begin
    next_mode      = mode;
    next_div_cnt   = div_cnt;
    next_tout_cnt  = tout_cnt;
    next_polarity  = polarity;
    next_dead_cnt  = dead_cnt;
    case (mode)
      HBS_LOCKOUT:
      begin
        if (supply_ok && vhigh && !fclr)
          next_mode = HBS_IGNITION;
      end
      HBS_IGNITION:
      begin
        if (vlow)
          next_mode = HBS_GENERAL;
        else if (tick_ign && tout_cnt == 11'(TOUT_TK - 1))
          next_mode = HBS_FAULT;
      end
      HBS_GENERAL:
      begin
        if (ovl || ocl)
          next_mode = HBS_BUCK_OFF;
      end
      HBS_BUCK_OFF:
      begin
        if (!ovl && !ocl && vlow)
          next_mode = HBS_GENERAL;
        else if (!ovl && !ocl && !vlow && !vhigh)
          next_mode = HBS_IGNITION;
      end
      HBS_FAULT:
      begin
        if (fclr)
          next_mode = HBS_LOCKOUT;
      end
      default:
        next_mode = HBS_LOCKOUT;
    endcase
    // fault request from the fault timer
    if (freq && running)
      next_mode = HBS_FAULT;
    if (!supply_ok)
      next_mode = HBS_LOCKOUT;

    if (mode != HBS_IGNITION)
      next_div_cnt = 8'h00;
    else if (tick_ign && next_mode == HBS_IGNITION)
    begin
      // divide by DIV, on phase first
      next_div_cnt  = div_wrap ? 8'h00 : div_cnt + 8'h01;
      next_tout_cnt = tout_cnt + 11'h001;
    end
    // Time-out restarts only from lockout
    if (!running)
      next_tout_cnt = 11'h000;

    if (running && tick_brg)
    begin
      next_polarity = !polarity;
      next_dead_cnt = 8'(DEAD_CYC);
    end
    else if (dead)
      next_dead_cnt = dead_cnt - 8'h01;
    // bridge stops in fault or lockout
    if (!running)
      next_dead_cnt = 8'h00;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode      <= HBS_LOCKOUT;
      div_cnt   <= 8'h00;
      tout_cnt  <= 11'h000;
      polarity  <= 1'b0;
      dead_cnt  <= 8'h00;
    end
    else if (i_ce)
    begin
      mode      <= next_mode;
      div_cnt   <= next_div_cnt;
      tout_cnt  <= next_tout_cnt;
      polarity  <= next_polarity;
      dead_cnt  <= next_dead_cnt;
    end
  end

  logic next_run;
  logic next_dead;
  logic next_gate_on;
  assign next_run     = (next_mode != HBS_LOCKOUT) &&
                        (next_mode != HBS_FAULT);
  assign next_dead    = next_dead_cnt != 8'h00;
  assign next_gate_on = next_run && !next_dead;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_high_side_a_gate    <= 1'b0;
      o_low_side_a_gate     <= 1'b0;
      o_high_side_b_gate    <= 1'b0;
      o_low_side_b_gate     <= 1'b0;
      o_buck_enable         <= 1'b0;
      o_strike_pulse_enable <= 1'b0;
      o_fault_latch         <= 1'b0;
      o_mode                <= 3'h0;
    end
    else if (i_ce)
    begin
      o_high_side_a_gate <= next_gate_on && next_polarity;
      o_low_side_b_gate  <= next_gate_on && next_polarity;
      o_low_side_a_gate  <= next_gate_on && !next_polarity;
      o_high_side_b_gate <= next_gate_on && !next_polarity;
      o_buck_enable      <= next_run && (next_mode != HBS_BUCK_OFF);
      o_strike_pulse_enable <= (next_mode == HBS_IGNITION) &&
                               (mode == HBS_IGNITION) &&
                               (next_div_cnt < 8'(ON_TK)) && next_gate_on;
      o_fault_latch <= next_mode == HBS_FAULT;
      o_mode        <= next_mode;
    end
  end

  logic any_gate;
  assign any_gate = o_high_side_a_gate | o_low_side_a_gate |
                    o_high_side_b_gate | o_low_side_b_gate;

  chk_no_shoot_through: assert property (@(posedge i_clk) disable iff (!rst_n)
    !(o_high_side_a_gate && o_low_side_a_gate))
    else $error("Half-bridge A shoot-through");
  chk_strike_dead: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_strike_pulse_enable |-> any_gate)
    else $error("Strike high without bridge on");
  chk_dead_gap: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce && running && tick_brg && next_run |=> !any_gate)
    else $error("No dead-time after toggle");
  chk_stop_fault: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_mode == 3'(HBS_FAULT) |-> !any_gate && !o_buck_enable)
    else $error("Bridge running in fault");
  chk_lockout_off: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_mode == 3'(HBS_LOCKOUT) |-> !any_gate && !o_fault_latch &&
    !o_strike_pulse_enable)
    else $error("Outputs active in lockout");
  chk_ignite_stop: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce && mode == HBS_IGNITION && vlow |=> !o_strike_pulse_enable)
    else $error("Strike still on after ignition");
  chk_fault_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce && mode == HBS_FAULT && !fclr && supply_ok |=> mode == HBS_FAULT)
    else $error("Fault left without clear");
  chk_start_cond: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce && mode == HBS_LOCKOUT && !(supply_ok && vhigh && !fclr)
    |=> mode == HBS_LOCKOUT)
    else $error("Left lockout without conditions");
  chk_timeout: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce && mode == HBS_IGNITION && tick_ign &&
    tout_cnt == 11'(TOUT_TK - 1) && !vlow && supply_ok |=> mode == HBS_FAULT)
    else $error("Ignition time-out missed");
  chk_divider_span: assert property (@(posedge i_clk) disable iff (!rst_n)
    div_cnt < 8'(ON_TK + OFF_TK))
    else $error("Strike divider beyond on and off span");

  cov_ignite: cover property (@(posedge i_clk) disable iff (!rst_n)
    mode == HBS_IGNITION ##1 mode == HBS_GENERAL);
  cov_strike: cover property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_strike_pulse_enable));
  cov_fault: cover property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_fault_latch));
endmodule : hbs_sequencer

/* File: tb/hbs_power_stage.sv */
// Model of the bridge switches and the strike circuit
`timescale 1ns/1ps
module hbs_power_stage (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Gate drives
  input  wire logic i_high_side_a_gate,
  input  wire logic i_low_side_a_gate,
  input  wire logic i_high_side_b_gate,
  input  wire logic i_low_side_b_gate,
  input  wire logic i_strike_pulse_enable,
  // Hazards seen
  output logic      o_shoot_through
);
  wire leg_a_short = i_high_side_a_gate && i_low_side_a_gate;
  wire leg_b_short = i_high_side_b_gate && i_low_side_b_gate;
  wire leg_a_float = !i_high_side_a_gate && !i_low_side_a_gate;
  wire leg_b_float = !i_high_side_b_gate && !i_low_side_b_gate;
  // legs never shorted, no pulse on floating midpoint
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      o_shoot_through <= 1'b0;
    else if (leg_a_short || leg_b_short
             || (i_strike_pulse_enable && (leg_a_float || leg_b_float)))
      o_shoot_through <= 1'b1;
endmodule : hbs_power_stage

/* File: tb/tb.sv */
// Self-checking bench for the ballast sequencer
`timescale 1ns/1ps
module tb;
  import hbs_pkg::*;
  localparam int DEAD = 3;
  localparam int DIV  = 5;
  localparam int ON   = 2;
  localparam int OFF  = 3;
  localparam int TOUT = 12;
  logic       clk = 0, rst_n = 0, sup = 0, upr = 0, low = 0, clr = 0;
  logic       ovl = 0, ocl = 0, frq = 0, stk = 0, brt = 0, ce = 1;
  logic       ha, la, hb, lb, buck, strike, flt, shoot;
  logic [2:0] mode;
  int         fails = 0, checks = 0, cyc = 0;
  wire  [3:0] gates = {ha, la, hb, lb};

  hbs_sequencer #(.DEAD_CYC(DEAD), .DIV(DIV), .ON_TK(ON), .OFF_TK(OFF),
    .TOUT_TK(TOUT)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_startup_threshold(sup), .i_above_upper_volt_limit(upr),
    .i_below_two_fifths_limit(low), .i_fault_clear(clr),
    .i_over_voltage_limit_level(ovl), .i_over_current_limit_level(ocl),
    .i_fault_request(frq), .i_strike_timer_tick(stk),
    .i_bridge_ramp_tick(brt), .o_high_side_a_gate(ha),
    .o_low_side_a_gate(la), .o_high_side_b_gate(hb),
    .o_low_side_b_gate(lb), .o_buck_enable(buck),
    .o_strike_pulse_enable(strike), .o_fault_latch(flt), .o_mode(mode));

  hbs_power_stage stage (
    .i_clk(clk), .i_rst_n(rst_n), .i_high_side_a_gate(ha),
    .i_low_side_a_gate(la), .i_high_side_b_gate(hb),
    .i_low_side_b_gate(lb), .i_strike_pulse_enable(strike),
    .o_shoot_through(shoot));

  always #5 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n)
    begin
      stk = 1;
      step(1);
      stk = 0;
      step(7);
    end
  endtask : ticks

  task automatic t_dead(input logic [3:0] nxt);
    int n;
    int w;
    n = 0;
    w = 0;
    brt = 1;
    step(1);
    brt = 0;
    while (gates !== 4'h0 && w < 10)
    begin
      w++;
      step(1);
    end
    while (gates === 4'h0 && n < 50)
    begin
      chk(strike, 1'b0);
      n++;
      step(1);
    end
    chk(16'(n), 16'(DEAD));
    chk(gates, nxt);
  endtask : t_dead

  task automatic t_start();
    chk({gates, buck, strike, flt, mode}, 16'h0000);
    sup = 1;
    upr = 1;
    clr = 1;
    step(10);
    chk(mode, HBS_LOCKOUT);
    clr = 0;
    step(5);
    chk(mode, HBS_IGNITION);
    chk(gates, 4'b0110);
    chk({buck, strike}, 2'b11);
  endtask : t_start

  task automatic t_freeze();
    logic [3:0] g;
    g = gates;
    ce = 0;
    brt = 1;
    step(1);
    brt = 0;
    step(8);
    chk(gates, g);
    ce = 1;
    step(8);
    chk({gates, mode}, {g, HBS_IGNITION});
  endtask : t_freeze

  task automatic t_strike();
    ticks(ON - 1);
    chk(strike, 1'b1);
    ticks(1);
    chk(strike, 1'b0);
    ticks(OFF - 1);
    chk(strike, 1'b0);
    ticks(1);
    chk(strike, 1'b1);
  endtask : t_strike

  task automatic t_timeout();
    ticks(TOUT - ON - OFF - 1);
    chk(mode, HBS_IGNITION);
    ticks(1);
    chk(mode, HBS_FAULT);
    chk({flt, gates, buck, strike}, 7'b1000000);
    brt = 1;
    step(1);
    brt = 0;
    step(8);
    chk(gates, 4'h0);
    clr = 1;
    step(6);
    chk({flt, mode}, {1'b0, HBS_LOCKOUT});
    clr = 0;
    step(6);
    chk(mode, HBS_IGNITION);
  endtask : t_timeout

  task automatic t_general();
    logic [3:0] g;
    low = 1;
    upr = 0;
    step(6);
    chk(mode, HBS_GENERAL);
    chk({buck, strike}, 2'b10);
    ovl = 1;
    step(6);
    chk({buck, mode}, {1'b0, HBS_BUCK_OFF});
    g = gates;
    t_dead(~g);
    ovl = 0;
    step(6);
    chk(mode, HBS_GENERAL);
    ocl = 1;
    step(6);
    chk({buck, mode}, {1'b0, HBS_BUCK_OFF});
    ocl = 0;
    low = 0;
    step(6);
    chk({buck, strike, mode}, {2'b11, HBS_IGNITION});
    frq = 1;
    step(6);
    chk({flt, gates, mode}, {5'b10000, HBS_FAULT});
    sup = 0;
    frq = 0;
    step(6);
    chk({flt, gates, buck, strike, mode}, 16'h0000);
  endtask : t_general

  initial
  begin
    step(12);
    rst_n = 1;
    step(4);
    t_start();
    t_freeze();
    t_dead(4'b1001);
    t_strike();
    t_timeout();
    t_general();
    chk(shoot, 1'b0);
    report_and_stop();
  end
endmodule : tb
